// ==== hw/prih_regs.svh ====
/*
 * constants for the register init and hold block: widths, reset values, timing counts.
 * assumes a 100 MHz core clock; included by bare name.
 */
`ifndef PRIH_REGS_SVH
`define PRIH_REGS_SVH
`define PRIH_NUM_REGS          10
`define PRIH_NUM_INPUTS        12
`define PRIH_SIG_BITS          64
`define PRIH_CLK_PERIOD_NS     10
`define PRIH_CLEAR_TIME_NS     1000
`define PRIH_CLEAR_CYCLES      ((`PRIH_CLEAR_TIME_NS) / (`PRIH_CLK_PERIOD_NS))
`define PRIH_CLEAR_CNT_W       8
`define PRIH_REG_RESET         1'b0
`define PRIH_SIG_RESET         64'h0000_0000_0000_0000
`endif

// ==== hw/prih_pkg.sv ====
/*
 * types shared by the register init and hold block.
 * assumes prih_regs.svh defines widths.
 */
`include "prih_regs.svh"
package prih_pkg;
    typedef enum logic [2:0] {
        PRIH_ST_CLEAR = 3'b001,
        PRIH_ST_RUN   = 3'b010,
        PRIH_ST_HOLD  = 3'b100
    } prih_state_t;
endpackage

// ==== hw/prih_sig_mem.sv ====
/*
 * user signature store: 64 bits, programmable, always readable.
 * assumes programming strobes are synchronous to the core clock.
 */
`timescale 1ns/1ps
`include "prih_regs.svh"
module prih_sig_mem #(
    parameter int SIG_W = `PRIH_SIG_BITS
) (
    input  wire logic             clk_i,
    input  wire logic             rst_i,
    input  wire logic             wr_i,
    input  wire logic [SIG_W-1:0] wr_data_i,
    output logic      [SIG_W-1:0] rd_data_o
);
    logic [SIG_W-1:0] sig_ff;
    logic [SIG_W-1:0] nxt_sig;

    // readback ignores the security setting on purpose
    always_comb begin
        nxt_sig = wr_i ? wr_data_i : sig_ff;
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            sig_ff <= SIG_W'(`PRIH_SIG_RESET);
        end else begin
            sig_ff <= nxt_sig;
        end
    end

    assign rd_data_o = sig_ff;
endmodule

// ==== hw/prih_core.sv ====
/*
 * register init and hold core: power-up clear, hold freeze, test preload, signature.
 * assumes RST_I is the single power-on indication; all other pins are synchronous.
 */
// Contract
// - after the power-up clear, while the hold pin is high and hold is enabled OUT_O, OUT_OE_O, COMB_O and CFG_RDATA_O keep their values;
//   the signature readback still follows writes.
// - an output disabled when hold began stays disabled for the whole hold.
// - during hold clock edges and input changes update no register except the signature store, and no result.
// - at power-up every register clears to zero without waiting for the clock.
// - after the clear each output pin shows zero through its configured polarity.
// - a preload path forces each register to one or zero for test.
// - a 64-bit user signature is programmable and readable even when secured.
// - during hold all logic inputs, the hold pin included, are blocked from the array.
// - with hold disabled the hold pin is an ordinary logic input.
// - once secured, configuration readback and preload are refused.
`timescale 1ns/1ps
`include "prih_regs.svh"
module prih_core
    import prih_pkg::*;
#(
    parameter int NREG = `PRIH_NUM_REGS,
    parameter int NIN  = `PRIH_NUM_INPUTS,
    parameter int SIGW = `PRIH_SIG_BITS
) (
    input  wire logic            CORE_CLK_I,
    input  wire logic            RST_I,
    input  wire logic            LOGIC_CLK_EN_I,
    input  wire logic [NIN-1:0]  LOGIC_IN_I,
    input  wire logic            SLEEP_HOLD_PIN_I,
    input  wire logic            HOLD_ENABLE_I,
    input  wire logic [NREG-1:0] OUT_INVERT_I,
    input  wire logic [NREG-1:0] OUT_ENABLE_CFG_I,
    input  wire logic            SECURE_I,
    input  wire logic            PRELOAD_I,
    input  wire logic [NREG-1:0] PRELOAD_DATA_I,
    input  wire logic            CFG_READ_I,
    input  wire logic [NREG-1:0] CFG_DATA_I,
    input  wire logic            SIG_WR_I,
    input  wire logic [SIGW-1:0] SIG_DATA_I,
    output logic      [NREG-1:0] OUT_O,
    output logic      [NREG-1:0] OUT_OE_O,
    output logic      [NREG-1:0] COMB_O,
    output logic      [NREG-1:0] CFG_RDATA_O,
    output logic                 PRELOAD_REFUSED_O,
    output logic                 CLEAR_BUSY_O,
    output logic      [SIGW-1:0] SIG_RDATA_O
);
    localparam int CLR_N = `PRIH_CLEAR_CYCLES;

    prih_state_t            state_ff, nxt_state;
    logic [`PRIH_CLEAR_CNT_W-1:0] clr_cnt_ff, nxt_clr_cnt;
    logic [NREG-1:0]        reg_ff, nxt_reg;
    logic [NREG-1:0]        out_ff, nxt_out;
    logic [NREG-1:0]        oe_ff, nxt_oe;
    logic [NREG-1:0]        comb_ff, nxt_comb;
    logic [NREG-1:0]        cfg_ff, nxt_cfg;
    logic                   refused_ff, nxt_refused;
    logic [SIGW-1:0]        sig_rd;
    logic [SIGW-1:0]        sig_ff;
    logic                   hold_act;
    logic [NIN:0]           array_in;

    // simple array stand-in: each register takes the parity of all inputs, its own feedback and input k
    function automatic logic [NREG-1:0] array_eval(input logic [NIN:0] in_v,
                                                   input logic [NREG-1:0] fb);
        logic [NREG-1:0] r;
        r = '0;
        for (int k = 0; k < NREG; k++) begin
            r[k] = ^in_v ^ fb[k] ^ in_v[k % (NIN + 1)];
        end
        return r;
    endfunction

    function automatic logic [NREG-1:0] pin_level(input logic [NREG-1:0] v,
                                                  input logic [NREG-1:0] inv);
        return v ^ inv;
    endfunction

    assign hold_act = HOLD_ENABLE_I && SLEEP_HOLD_PIN_I;
    // the hold pin joins the array only when the hold feature is off
    assign array_in = {HOLD_ENABLE_I ? 1'b0 : SLEEP_HOLD_PIN_I, LOGIC_IN_I};

    always_comb begin
        nxt_state   = state_ff;
        nxt_clr_cnt = clr_cnt_ff;
        nxt_reg     = reg_ff;
        nxt_out     = out_ff;
        nxt_oe      = oe_ff;
        nxt_comb    = comb_ff;
        nxt_cfg     = cfg_ff;
        nxt_refused = 1'b0;
        case (state_ff)
            PRIH_ST_CLEAR: begin
                // registers stay at zero; clock is expected quiet here
                nxt_reg = {NREG{`PRIH_REG_RESET}};
                nxt_out = pin_level({NREG{`PRIH_REG_RESET}}, OUT_INVERT_I);
                nxt_oe  = OUT_ENABLE_CFG_I;
                if (clr_cnt_ff == `PRIH_CLEAR_CNT_W'(CLR_N - 1)) begin
                    nxt_state = PRIH_ST_RUN;
                end else begin
                    nxt_clr_cnt = clr_cnt_ff + `PRIH_CLEAR_CNT_W'(1);
                end
            end
            PRIH_ST_RUN: begin
                if (hold_act) begin
                    nxt_state = PRIH_ST_HOLD;
                end else begin
                    if (PRELOAD_I && !SECURE_I) begin
                        nxt_reg = PRELOAD_DATA_I;
                    end else if (LOGIC_CLK_EN_I) begin
                        // first edge assumes inputs settled
                        nxt_reg = array_eval(array_in, reg_ff);
                    end
                    nxt_refused = PRELOAD_I && SECURE_I;
                    if (CFG_READ_I && !SECURE_I) begin
                        nxt_cfg = CFG_DATA_I;
                    end else if (CFG_READ_I) begin
                        nxt_cfg = '0;
                    end
                    nxt_out  = pin_level(nxt_reg, OUT_INVERT_I);
                    nxt_oe   = OUT_ENABLE_CFG_I;
                    nxt_comb = array_eval(array_in, reg_ff);
                end
            end
            PRIH_ST_HOLD: begin
                // every value except the signature frozen; inputs and clock enables are blocked
                // a preload strobe is an input as well, so it raises no refusal here
                nxt_refused = 1'b0;
                if (!hold_act) begin
                    nxt_state = PRIH_ST_RUN;
                end
            end
            default: begin
                nxt_state = PRIH_ST_CLEAR;
            end
        endcase
    end

    // a single power-on reset clears everything without the clock
    always_ff @(posedge CORE_CLK_I or posedge RST_I) begin
        if (RST_I) begin
            state_ff   <= PRIH_ST_CLEAR;
            clr_cnt_ff <= '0;
            reg_ff     <= '0;
            out_ff     <= '0;
            oe_ff      <= '0;
            comb_ff    <= '0;
            cfg_ff     <= '0;
            refused_ff <= 1'b0;
            sig_ff     <= '0;
        end else begin
            state_ff   <= nxt_state;
            clr_cnt_ff <= nxt_clr_cnt;
            reg_ff     <= nxt_reg;
            out_ff     <= nxt_out;
            oe_ff      <= nxt_oe;
            comb_ff    <= nxt_comb;
            cfg_ff     <= nxt_cfg;
            refused_ff <= nxt_refused;
            sig_ff     <= sig_rd;
        end
    end

    prih_sig_mem #(
        .SIG_W     (SIGW)
    ) u_sig (
        .clk_i     (CORE_CLK_I),
        .rst_i     (RST_I),
        .wr_i      (SIG_WR_I),
        .wr_data_i (SIG_DATA_I),
        .rd_data_o (sig_rd)
    );

    assign OUT_O             = out_ff;
    assign OUT_OE_O          = oe_ff;
    assign COMB_O            = comb_ff;
    assign CFG_RDATA_O       = cfg_ff;
    assign PRELOAD_REFUSED_O = refused_ff;
    assign CLEAR_BUSY_O      = state_ff[0];
    assign SIG_RDATA_O       = sig_ff;

    sequence s_hold_in;
        state_ff == PRIH_ST_HOLD;
    endsequence

    a_hold_keeps_out: assert property (@(posedge CORE_CLK_I) disable iff (RST_I)
        s_hold_in ##1 s_hold_in |-> $stable(OUT_O) && $stable(COMB_O))
        else $error("outputs moved during hold");

    a_hold_keeps_oe: assert property (@(posedge CORE_CLK_I) disable iff (RST_I)
        s_hold_in ##1 s_hold_in |-> $stable(OUT_OE_O))
        else $error("output enable moved during hold");

    a_hold_no_update: assert property (@(posedge CORE_CLK_I) disable iff (RST_I)
        (state_ff == PRIH_ST_HOLD) && hold_act |=> $stable(reg_ff))
        else $error("register updated during hold");

    a_clear_zero_regs: assert property (@(posedge CORE_CLK_I) disable iff (RST_I)
        state_ff == PRIH_ST_CLEAR |-> reg_ff == '0)
        else $error("register not cleared at power-up");

    a_clear_out_polar: assert property (@(posedge CORE_CLK_I) disable iff (RST_I)
        state_ff == PRIH_ST_CLEAR && $stable(OUT_INVERT_I) ##1 state_ff == PRIH_ST_CLEAR
        |-> OUT_O == $past(OUT_INVERT_I))
        else $error("cleared output ignores polarity");

    a_preload_forces: assert property (@(posedge CORE_CLK_I) disable iff (RST_I)
        state_ff == PRIH_ST_RUN && !hold_act && PRELOAD_I && !SECURE_I
        |=> reg_ff == $past(PRELOAD_DATA_I))
        else $error("preload value not loaded");

    a_sig_readable: assert property (@(posedge CORE_CLK_I) disable iff (RST_I)
        SIG_WR_I |-> ##2 SIG_RDATA_O == $past(SIG_DATA_I, 2) || $past(SIG_WR_I))
        else $error("signature not readable after write");

    a_secure_refuse: assert property (@(posedge CORE_CLK_I) disable iff (RST_I)
        state_ff == PRIH_ST_RUN && !hold_act && !LOGIC_CLK_EN_I && PRELOAD_I && SECURE_I
        |=> PRELOAD_REFUSED_O && $stable(reg_ff))
        else $error("preload accepted while secured");

    a_clear_length: assert property (@(posedge CORE_CLK_I) disable iff (RST_I)
        $rose(state_ff == PRIH_ST_RUN) |-> $past(clr_cnt_ff) == `PRIH_CLEAR_CNT_W'(CLR_N - 1))
        else $error("clear interval wrong length");
endmodule

// ==== dv/prih_sys_model.sv ====
/*
 * far-side system logic model: device clock enables, logic inputs, hold pin.
 * assumes the core clock and the clear-busy flag of the core.
 */
`timescale 1ns/1ps
module prih_sys_model (
    input  wire logic        clk_i,
    input  wire logic        busy_i,
    input  wire logic        run_i,
    input  wire logic        hold_i,
    output logic             clk_en_o,
    output logic [11:0]      in_o,
    output logic             hold_pin_o
);
    int   seed = 40;
    logic settle_ff = 1'b1;
    assign hold_pin_o = hold_i;
    // posedge with non-blocking so the core samples the old values
    always @(posedge clk_i) begin
        settle_ff <= busy_i;
        clk_en_o <= run_i && !busy_i && !settle_ff && (($random(seed) & 1) != 0);
        in_o <= 12'($random(seed));
    end
endmodule

// ==== dv/prih_core_test.sv ====
/*
 * self-checking bench for the init and hold core, scoreboard by queue.
 * assumes the system model drives clock enables, logic inputs and hold pin.
 */
`timescale 1ns/1ps
module prih_core_test;
    import prih_pkg::*;
    typedef struct { int due; int k; logic [63:0] v; } prih_note_t;
    logic clk = 1'b0, rst = 1'b1, hold = 1'b0, run = 1'b0, secure = 1'b0, hold_en = 1'b1;
    logic pre = 1'b0, cfg_rd = 1'b0, sig_wr = 1'b0, clk_en, hpin;
    logic [9:0]  inv, oe_cfg, oe_old, pre_d, cfg_d, exp_out, out_o, oe_o, comb_o, crd_o;
    logic [9:0]  exp_comb;
    logic [11:0] lin;
    logic [63:0] sig_d, srd_o;
    logic        refused_o, busy_o;
    int          seed = 40, cyc = 0, n_mismatch = 0, n_checks = 0, i;
    prih_note_t  notes[$];
    prih_note_t  nt;
    initial forever #5 clk = ~clk;
    always @(posedge clk) cyc <= cyc + 1;
    prih_core i_prih_core (.CORE_CLK_I(clk), .RST_I(rst), .LOGIC_CLK_EN_I(clk_en),
        .LOGIC_IN_I(lin), .SLEEP_HOLD_PIN_I(hpin), .HOLD_ENABLE_I(hold_en),
        .OUT_INVERT_I(inv), .OUT_ENABLE_CFG_I(oe_cfg), .SECURE_I(secure), .PRELOAD_I(pre),
        .PRELOAD_DATA_I(pre_d), .CFG_READ_I(cfg_rd), .CFG_DATA_I(cfg_d), .SIG_WR_I(sig_wr),
        .SIG_DATA_I(sig_d), .OUT_O(out_o), .OUT_OE_O(oe_o), .COMB_O(comb_o),
        .CFG_RDATA_O(crd_o), .PRELOAD_REFUSED_O(refused_o), .CLEAR_BUSY_O(busy_o),
        .SIG_RDATA_O(srd_o));
    prih_sys_model i_prih_sys_model (.clk_i(clk), .busy_i(busy_o), .run_i(run),
        .hold_i(hold), .clk_en_o(clk_en), .in_o(lin), .hold_pin_o(hpin));
    task automatic check(input string nm, input logic [63:0] seen, input logic [63:0] exp);
        n_checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic expect_v(input int dly, input int k, input logic [63:0] v);
        notes.push_back('{cyc + dly, k, v});
    endtask
    task automatic summarize();
        $display("checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    // parity stand-in of the array: bit k sees all inputs, its own feedback and input k
    function automatic logic [9:0] par_model(input logic [12:0] v, input logic [9:0] r);
        logic [9:0] m;
        m = 10'h000;
        for (int k = 0; k < 10; k++) begin
            m[k] = (^v) ^ r[k] ^ v[k];
        end
        return m;
    endfunction
    // results are settled by the falling edge
    always @(negedge clk) begin
        while (notes.size() > 0 && notes[0].due <= cyc) begin
            nt = notes.pop_front();
            case (nt.k)
                0: check("out", 64'(out_o), nt.v);
                1: check("oe", 64'(oe_o), nt.v);
                2: check("readback", 64'(crd_o), nt.v);
                3: check("refused", 64'(refused_o), nt.v);
                5: check("comb", 64'(comb_o), nt.v);
                default: check("signature", srd_o, nt.v);
            endcase
        end
    end
    task automatic wait_clear();
        int n;
        n = 0;
        while (busy_o === 1'b1 && n < 300) begin
            n++;
            @(negedge clk);
        end
        check("clear", 64'(n >= 99 && n <= 101), 64'h1);
        expect_v(1, 0, 64'(inv));
        expect_v(1, 1, 64'(oe_cfg));
        @(negedge clk);
    endtask
    initial begin
        inv = 10'($random(seed));
        oe_cfg = 10'($random(seed));
        pre_d = 10'h000;
        cfg_d = 10'h000;
        sig_d = 64'h0;
        repeat (5) @(negedge clk);
        check("busy", 64'(busy_o), 64'h1);
        check("out", 64'(out_o), 64'h0);
        check("comb", 64'(comb_o), 64'h0);
        rst = 1'b0;
        wait_clear();
        for (i = 0; i < 8; i++) begin
            pre = 1'b1;
            pre_d = (i == 0) ? 10'h3ff : (i == 1) ? 10'h000 : 10'($random(seed));
            expect_v(1, 0, 64'(pre_d ^ inv));
            @(negedge clk);
        end
        pre = 1'b0;
        exp_out = pre_d ^ inv;
        cfg_rd = 1'b1;
        cfg_d = 10'($random(seed));
        expect_v(1, 2, 64'(cfg_d));
        @(negedge clk);
        secure = 1'b1;
        pre = 1'b1;
        pre_d = ~pre_d;
        expect_v(1, 2, 64'h0);
        expect_v(1, 3, 64'h1);
        expect_v(1, 0, 64'(exp_out));
        @(negedge clk);
        pre = 1'b0;
        cfg_rd = 1'b0;
        sig_wr = 1'b1;
        sig_d = {$random(seed), $random(seed)};
        expect_v(1, 3, 64'h0);
        expect_v(2, 4, sig_d);
        @(negedge clk);
        sig_wr = 1'b0;
        repeat (2) @(negedge clk);
        secure = 1'b0;
        pre = 1'b1;
        // the array result of this edge is the one the hold must keep
        exp_comb = par_model({1'b0, lin}, exp_out ^ inv);
        pre_d = 10'($random(seed));
        exp_out = pre_d ^ inv;
        oe_old = oe_cfg;
        expect_v(1, 0, 64'(exp_out));
        @(negedge clk);
        pre = 1'b0;
        hold = 1'b1;
        run = 1'b1;
        @(negedge clk);
        // clock enables and inputs keep moving; nothing may reach the registers
        pre = 1'b1;
        pre_d = ~pre_d;
        oe_cfg = ~oe_cfg;
        for (i = 0; i < 8; i++) begin
            expect_v(1, 0, 64'(exp_out));
            expect_v(1, 1, 64'(oe_old));
            expect_v(1, 5, 64'(exp_comb));
            @(negedge clk);
        end
        pre = 1'b0;
        run = 1'b0;
        repeat (2) @(negedge clk);
        hold = 1'b0;
        repeat (2) @(negedge clk);
        expect_v(1, 0, 64'(exp_out));
        expect_v(1, 1, 64'(oe_cfg));
        repeat (2) @(negedge clk);
        // hold feature off: the pin is a plain array input and freezes nothing
        hold_en = 1'b0;
        hold = 1'b1;
        pre = 1'b1;
        exp_comb = par_model({1'b1, lin}, exp_out ^ inv);
        pre_d = 10'($random(seed));
        exp_out = pre_d ^ inv;
        expect_v(1, 0, 64'(exp_out));
        expect_v(1, 5, 64'(exp_comb));
        @(negedge clk);
        pre = 1'b0;
        hold = 1'b0;
        hold_en = 1'b1;
        repeat (2) @(negedge clk);
        #3 rst = 1'b1;
        #1 check("out", 64'(out_o), 64'h0);
        check("comb", 64'(comb_o), 64'h0);
        @(negedge clk);
        rst = 1'b0;
        wait_clear();
        repeat (3) @(negedge clk);
        summarize();
    end
    initial begin
        #(5000 * 10);
        n_mismatch++;
        summarize();
    end
endmodule
